/* design/uart_async_rx_recovery.sv */
`timescale 1ns/1ns
module uart_async_rx_recovery
    import uart_rx_pkg::*;
#(
    parameter int unsigned DIV_WIDTH = DIV_W
)
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // serial line
    input  wire logic                 serial_rx_pin,
    // configuration
    input  wire logic                 receiver_enable_bit,
    input  wire logic                 double_speed_select,
    input  wire logic [DIV_WIDTH-1:0] baud_divisor,
    input  wire logic [3:0]           char_bits,
    input  wire logic                 parity_enable,
    // receive buffer head
    input  wire logic                 rx_read,
    output logic                      rx_valid,
    output logic [DATA_W-1:0]         rx_data,
    output logic                      frame_error_flag,
    output logic                      overrun_flag
);
    sample_if smp ();

    rx_state_type      state;
    logic [SMP_W-1:0]  scount;
    logic [BIDX_W-1:0] bit_idx;
    logic [2:0]        votes;
    logic              last_sample;
    logic [DATA_W-1:0] shreg;
    logic              pend_valid;
    logic [DATA_W-1:0] pend_data;
    logic              pend_fe;
    logic              tail_valid;
    logic [DATA_W-1:0] tail_data;
    logic              tail_fe;

    wire logic         en   = receiver_enable_bit;
    wire logic         tick = smp.tick;
    wire logic         rx   = smp.rx;
    logic [SMP_W-1:0]  spb;
    logic [SMP_W-1:0]  vote_first;
    logic [SMP_W-1:0]  vote_last;
    logic [BIDX_W-1:0] nbits;
    logic [2:0]        cur_votes;
    logic              bitval;
    logic              at_vote_last;
    logic              start_seen;
    logic              start_ok;
    logic              frame_done;
    logic              pop;
    logic              push;

    // =====================================================
    // line synchroniser and sample tick
    rx_sampler u_sampler (
        .clk           (clk),
        .rst_b         (rst_b),
        .serial_rx_pin (serial_rx_pin),
        .baud_divisor  (baud_divisor[DIV_W-1:0]),
        .smp           (smp.src)
    );

    // =====================================================
    // mode figures and vote decisions
    assign spb          = double_speed_select ? SPB_DOUBLE : SPB_NORMAL;
    assign vote_first   = double_speed_select ? QUAL_DOUBLE : QUAL_NORMAL;
    assign vote_last    = vote_first + VOTE_SPAN;
    assign nbits        = char_bits + {3'h0, parity_enable};
    assign cur_votes    = {votes[1:0], rx};
    assign bitval       = majority3(cur_votes);
    assign at_vote_last = tick && scount == vote_last;
    assign start_seen   = en && state == ST_IDLE && tick && last_sample && !rx;
    assign start_ok     = en && state == ST_START && at_vote_last && !bitval;
    assign frame_done   = en && state == ST_BITS && at_vote_last && bit_idx == nbits;
    assign pop          = rx_read && rx_valid;
    assign push         = pend_valid && (!tail_valid || pop);

    // =====================================================
    // previous sample for edge search
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_sample <= LINE_IDLE;
        end else if (tick) begin
            last_sample <= rx;
        end
    end

    // =====================================================
    // start detection and bit sequencing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state   <= ST_IDLE;
            scount  <= '0;
            bit_idx <= '0;
            votes   <= '0;
        end else if (!en) begin
            state   <= ST_IDLE;
            scount  <= '0;
            bit_idx <= '0;
        end else if (tick) begin
            if (scount >= vote_first && scount <= vote_last) begin
                votes <= cur_votes;
            end
            case (state)
                ST_IDLE: begin
                    if (last_sample && !rx) begin
                        state  <= ST_START;
                        scount <= SMP_FIRST + 1'b1;  // this tick was sample one; count names the next
                    end
                end
                ST_START: begin
                    if (scount == vote_last && bitval) begin
                        state <= ST_IDLE;
                    end else if (scount == spb) begin
                        state   <= ST_BITS;
                        scount  <= SMP_FIRST;
                        bit_idx <= '0;
                    end else begin
                        scount <= scount + 1'b1;
                    end
                end
                ST_BITS: begin
                    if (scount == vote_last && bit_idx == nbits) begin
                        // later bits, extra stops included, never looked at
                        state <= double_speed_select ? ST_TAIL : ST_IDLE;
                    end else if (scount == spb) begin
                        scount  <= SMP_FIRST;
                        bit_idx <= bit_idx + 1'b1;
                    end else begin
                        scount <= scount + 1'b1;
                    end
                end
                ST_TAIL: begin
                    // one sample later before double speed accepts an edge
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // =====================================================
    // data shifter, cleared per frame so short characters read zero above
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shreg <= '0;
        end else if (start_ok) begin
            shreg <= '0;
        end else if (en && state == ST_BITS && at_vote_last && bit_idx < char_bits) begin
            shreg[bit_idx] <= bitval;
        end
    end

    // =====================================================
    // completed character copied from the shifter, waiting in pend_data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_valid <= 1'b0;
            pend_data  <= '0;
            pend_fe    <= 1'b0;
        end else if (!en) begin
            pend_valid <= 1'b0;
        end else if (frame_done) begin
            pend_valid <= 1'b1;  // an unmoved older character is lost here
            pend_data  <= shreg;
            pend_fe    <= !bitval;
        end else if (push) begin
            pend_valid <= 1'b0;
        end
    end

    // =====================================================
    // two-entry receive buffer; head drives the outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_valid         <= 1'b0;
            rx_data          <= '0;
            frame_error_flag <= 1'b0;
            tail_valid       <= 1'b0;
            tail_data        <= '0;
            tail_fe          <= 1'b0;
        end else if (!en) begin
            rx_valid   <= 1'b0;
            tail_valid <= 1'b0;
        end else if (pop) begin
            if (tail_valid) begin
                rx_data          <= tail_data;
                frame_error_flag <= tail_fe;
                tail_valid       <= push;
                tail_data        <= pend_data;
                tail_fe          <= pend_fe;
            end else begin
                rx_valid         <= push;
                rx_data          <= pend_data;
                frame_error_flag <= pend_fe;
            end
        end else if (push) begin
            if (!rx_valid) begin
                rx_valid         <= 1'b1;
                rx_data          <= pend_data;
                frame_error_flag <= pend_fe;
            end else begin
                tail_valid <= 1'b1;
                tail_data  <= pend_data;
                tail_fe    <= pend_fe;
            end
        end
    end

    // =====================================================
    // overrun: set wins over the clear by a successful move
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            overrun_flag <= 1'b0;
        end else if (!en) begin
            overrun_flag <= 1'b0;
        end else if (start_ok && tail_valid && pend_valid && !pop) begin
            overrun_flag <= 1'b1;
        end else if (push) begin
            overrun_flag <= 1'b0;
        end
    end

    // =====================================================
    // checks
    property p_edge_start;
        @(posedge clk) disable iff (!rst_b)
        start_seen |=> (state == ST_START && scount == 5'h02);
    endproperty
    a_edge_start: assert property (p_edge_start) else $error("falling edge missed");
    property p_noise;
        @(posedge clk) disable iff (!rst_b)
        (en && state == ST_START && at_vote_last && bitval) |=> state == ST_IDLE;
    endproperty
    a_noise: assert property (p_noise) else $error("noise start not rejected");
    property p_qual_pos;
        @(posedge clk) disable iff (!rst_b)
        start_ok |-> (scount == (double_speed_select ? 5'h06 : 5'h0a));
    endproperty
    a_qual_pos: assert property (p_qual_pos) else $error("wrong qualification sample");
    property p_align;
        @(posedge clk) disable iff (!rst_b)
        (en && state == ST_START && tick && scount == spb) |=> (state == ST_BITS && scount == 5'h01);
    endproperty
    a_align: assert property (p_align) else $error("bit timing not realigned");
    property p_states;
        @(posedge clk) disable iff (!rst_b)
        (state == ST_BITS) |-> (scount >= 5'h01 && scount <= (double_speed_select ? 5'h08 : 5'h10));
    endproperty
    a_states: assert property (p_states) else $error("sample state out of range");
    property p_frame_err;
        @(posedge clk) disable iff (!rst_b)
        frame_done |=> (pend_valid && pend_fe == !$past(bitval));
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("frame error not recorded");
    property p_rearm;
        @(posedge clk) disable iff (!rst_b)
        (frame_done && !double_speed_select) |=> state == ST_IDLE;
    endproperty
    a_rearm: assert property (p_rearm) else $error("not ready after stop vote");
    property p_disable;
        @(posedge clk) disable iff (!rst_b)
        !en |=> (state == ST_IDLE && !rx_valid && !pend_valid && !overrun_flag);
    endproperty
    a_disable: assert property (p_disable) else $error("disable did not flush");
    property p_overrun;
        @(posedge clk) disable iff (!rst_b)
        (start_ok && tail_valid && pend_valid && !pop) |=> overrun_flag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    c_frame: cover property (@(posedge clk) disable iff (!rst_b) frame_done && bitval);
    c_noise: cover property (@(posedge clk) disable iff (!rst_b) en && state == ST_START && at_vote_last && bitval);
    c_fe:    cover property (@(posedge clk) disable iff (!rst_b) frame_done && !bitval);
    c_ovr:   cover property (@(posedge clk) disable iff (!rst_b) $rose(overrun_flag));
endmodule

/* inc/uart_rx_pkg.sv */
package uart_rx_pkg;
    // =====================================================
    // widths
    localparam int unsigned DIV_W     = 12;  // baud divisor width
    localparam int unsigned DATA_W    = 9;   // widest character
    localparam int unsigned SMP_W     = 5;   // sample counter width
    localparam int unsigned BIDX_W    = 4;   // bit index width

    // =====================================================
    // sampling figures
    localparam logic [SMP_W-1:0] SPB_NORMAL  = 5'h10;  // samples per bit, normal
    localparam logic [SMP_W-1:0] SPB_DOUBLE  = 5'h08;  // samples per bit, double speed
    localparam logic [SMP_W-1:0] QUAL_NORMAL = 5'h08;  // first centre sample, normal
    localparam logic [SMP_W-1:0] QUAL_DOUBLE = 5'h04;  // first centre sample, double speed
    localparam logic [SMP_W-1:0] VOTE_SPAN   = 5'h02;  // last centre minus first
    localparam logic [SMP_W-1:0] SMP_FIRST   = 5'h01;  // first low sample number
    localparam logic              LINE_IDLE   = 1'b1;

    // =====================================================
    // receiver states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_START = 4'h2,
        ST_BITS  = 4'h4,
        ST_TAIL  = 4'h8
    } rx_state_type;

    // two of three wins
    function automatic logic majority3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction
endpackage

/* inc/sample_if.sv */
`timescale 1ns/1ns
interface sample_if;
    logic tick;  // one sample instant
    logic rx;    // synchronised receive line
    modport src (output tick, output rx);
    modport dst (input tick, input rx);
endinterface

/* design/rx_sampler.sv */
`timescale 1ns/1ns
module rx_sampler
    import uart_rx_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // line and rate
    input  wire logic             serial_rx_pin,
    input  wire logic [DIV_W-1:0] baud_divisor,
    // sample stream
    sample_if.src                 smp
);
    logic             meta;
    logic             sync;
    logic [DIV_W-1:0] count;
    logic             tick;

    // =====================================================
    // two-flop synchroniser, idle high out of reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= LINE_IDLE;
            sync <= LINE_IDLE;
        end else begin
            meta <= serial_rx_pin;
            sync <= meta;
        end
    end

    // =====================================================
    // sample tick every divisor+1 clocks; divisor rounding is the receiver's share of rate error
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == '0) begin
            count <= baud_divisor;
            tick  <= 1'b1;
        end else begin
            count <= count - 1'b1;
            tick  <= 1'b0;
        end
    end

    assign smp.tick = tick;
    assign smp.rx   = sync;

    property p_tick_gap;
        @(posedge clk) disable iff (!rst_b)
        (tick && baud_divisor != '0 && count != '0) |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("sample ticks too close");
endmodule

/* tb/rx_line_driver.sv */
`timescale 1ns/1ns
// =====================================================
// remote serial transmitter model
module rx_line_driver (
    // clock
    input  wire logic clk,
    // serial line
    output logic      line
);
    // idle line is high until the first frame
    initial line = 1'b1;

    // one frame, lsb first, parity bit the xor of all nine data bits, one stop bit of stop_clk clocks
    // glitch flips two clocks mid-bit: exactly one tick wide at divisor 1
    task automatic send(input logic [8:0] data, input int nbits, input logic par_en,
                        input logic stop, input int bit_clk, input int stop_clk, input logic glitch);
        logic val;
        int   last;
        last = nbits + (par_en ? 1 : 0) + 1;
        for (int i = 0; i <= last; i++) begin
            if (i == 0) val = 1'b0;
            else if (i <= nbits) val = data[i-1];
            else if (i < last) val = ^data;
            else val = stop;
            for (int c = 0; c < ((i == last) ? stop_clk : bit_clk); c++) begin
                @(posedge clk);
                #1;
                // same rate as the receiver, no drift
                line = (glitch && i > 0 && i <= nbits && (c >> 1) == (bit_clk >> 2)) ? ~val : val;
            end
        end
        // line idles high: any further stop bits look the same
        @(posedge clk);
        #1;
        line = 1'b1;
    endtask

    // low spike shorter than the start qualification window
    task automatic pulse(input int clks);
        @(posedge clk);
        #1;
        line = 1'b0;
        repeat (clks) @(posedge clk);
        #1;
        line = 1'b1;
    endtask
endmodule

/* tb/test_uart_async_rx_recovery.sv */
`timescale 1ns/1ns
// =====================================================
// receive front end bench
module test_uart_async_rx_recovery;
    import uart_rx_pkg::*;
    logic              clk;
    logic              rst_b;
    logic              line;
    logic              en;
    logic              dbl;
    logic [DIV_W-1:0]  div;
    logic [3:0]        nb;
    logic              par;
    logic              rd;
    logic              rx_valid;
    logic [DATA_W-1:0] rx_data;
    logic              fe;
    logic              ovr;
    int                n_fail;
    int                n_compared;

    // =====================================================
    // instances
    uart_async_rx_recovery #(.DIV_WIDTH(DIV_W)) uart_async_rx_recovery_i (
        .clk(clk), .rst_b(rst_b), .serial_rx_pin(line), .receiver_enable_bit(en),
        .double_speed_select(dbl), .baud_divisor(div), .char_bits(nb), .parity_enable(par),
        .rx_read(rd), .rx_valid(rx_valid), .rx_data(rx_data), .frame_error_flag(fe),
        .overrun_flag(ovr));
    rx_line_driver rx_line_driver_i (.clk(clk), .line(line));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // =====================================================
    // helpers
    task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    // wait for the head character, compare, pop it
    task automatic recv(input logic [DATA_W-1:0] exp, input logic exp_fe);
        for (int k = 0; k < 2000 && rx_valid !== 1'b1; k++) @(posedge clk);
        #1;
        check("rx_valid", 9'h001, {8'h00, rx_valid});
        check("rx_data", exp, rx_data);
        check("frame_error_flag", {8'h00, exp_fe}, {8'h00, fe});
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic results();
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog: the frames need some 6500 clocks; three times that as margin
    initial begin
        #200000;
        n_fail++;
        results();
    end

    // =====================================================
    // main sequence
    initial begin
        logic [8:0] c_data [4];
        int         c_bits [4];
        logic       c_par  [4];
        logic       c_stop [4];
        logic       c_gl   [4];
        int         bc;
        c_data = '{9'h0a5, 9'h03c, 9'h1b5, 9'h155};
        c_bits = '{8, 8, 5, 9};
        c_par  = '{1'b0, 1'b0, 1'b1, 1'b1};
        c_stop = '{1'b1, 1'b0, 1'b1, 1'b1};
        c_gl   = '{1'b0, 1'b0, 1'b0, 1'b1};
        n_fail = 0;
        n_compared = 0;
        rst_b = 1'b0;
        en = 1'b1;
        dbl = 1'b0;
        div = 12'h001;
        nb = 4'h8;
        par = 1'b0;
        rd = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        check("reset rx_valid", 9'h000, {7'h00, rx_valid, ovr});
        // both modes, three formats, majority across a glitch, stop bit vote
        for (int m = 0; m < 2; m++) begin
            dbl = m[0];
            bc = (m == 0) ? 32 : 16;
            for (int c = 0; c < 4; c++) begin
                nb = c_bits[c][3:0];
                par = c_par[c];
                rx_line_driver_i.send(c_data[c], c_bits[c], c_par[c], c_stop[c], bc, bc, c_gl[c]);
                recv(c_data[c] & ((9'h001 << c_bits[c]) - 9'h001), ~c_stop[c]);
            end
            // spike of one or two ticks must be dropped, then search resumes
            rx_line_driver_i.pulse(bc >> 3);
            repeat (400) @(posedge clk);
            check("noise rx_valid", 9'h000, {8'h00, rx_valid});
            rx_line_driver_i.send(9'h0c3, 9, 1'b1, 1'b1, bc, bc, 1'b0);
            recv(9'h0c3, 1'b0);
        end
        // normal mode, stop cut short: next start right after the stop vote
        dbl = 1'b0;
        nb = 4'h8;
        par = 1'b0;
        rx_line_driver_i.send(9'h081, 8, 1'b0, 1'b1, 32, 24, 1'b0);
        rx_line_driver_i.send(9'h07e, 8, 1'b0, 1'b1, 32, 32, 1'b0);
        recv(9'h081, 1'b0);
        recv(9'h07e, 1'b0);
        // two in buffer, one pending, fourth start overruns
        for (int i = 0; i < 4; i++) begin
            rx_line_driver_i.send(9'h011 * i, 8, 1'b0, 1'b1, 32, 32, 1'b0);
            if (i == 2) check("overrun early", 9'h000, {8'h00, ovr});
        end
        check("overrun", 9'h001, {8'h00, ovr});
        recv(9'h000, 1'b0);
        check("overrun clear", 9'h000, {8'h00, ovr});
        // disable flushes buffer and drops the frame in flight
        fork
            rx_line_driver_i.send(9'h0f0, 8, 1'b0, 1'b1, 32, 32, 1'b0);
            begin
                repeat (100) @(posedge clk);
                #1;
                en = 1'b0;
            end
        join
        @(posedge clk);
        #1;
        check("flush", 9'h000, {7'h00, rx_valid, ovr});
        en = 1'b1;
        repeat (100) @(posedge clk);
        #1;
        check("dropped frame", 9'h000, {8'h00, rx_valid});
        // clean reception after re-enable, slower divisor
        div = 12'h003;
        rx_line_driver_i.send(9'h05a, 8, 1'b0, 1'b1, 64, 64, 1'b0);
        recv(9'h05a, 1'b0);
        results();
    end
endmodule
